// >>> adc_seq_pkg.sv
package adc_seq_pkg;

    // Register byte offsets on the 32-bit bus.
    localparam logic [4:0] OFF_CTRL_A  = 5'h00;
    localparam logic [4:0] OFF_CTRL_B  = 5'h04;
    localparam logic [4:0] OFF_RES_HI  = 5'h08;
    localparam logic [4:0] OFF_RES_LO  = 5'h0C;
    localparam logic [4:0] OFF_FLAG    = 5'h10;
    localparam logic [4:0] OFF_IRQ_EN  = 5'h14;

    // Field positions.
    localparam int EN_BIT     = 0;
    localparam int GO_BIT     = 1;
    localparam int WIDTH_BIT  = 7;
    localparam int FMT_BIT    = 7;
    localparam int SEL_LSB    = 4;
    localparam int DONE_BIT   = 0;
    localparam int IRQ_EN_BIT = 0;

    // Values after reset.
    localparam logic [2:0]  CLKSEL_RST = 3'h0;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    // Conversion timing.
    localparam logic [3:0] PERIODS_LAST = 4'hE;   // Fifteen bit periods, 0 to 14.
    localparam logic [3:0] PERIOD_SIGN  = 4'h1;
    localparam logic [3:0] PERIOD_LSB   = 4'hD;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_TIME_NS = 40;
    localparam int INSTR_CYCLES  = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRC_PERIOD_NS = 1600;
    localparam int FRC_CYCLES    = FRC_PERIOD_NS / CLK_PERIOD_NS;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV  = 2'b10
    } seq_state_t;

endpackage

// >>> adc_conversion_sequencer.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
module adc_conversion_sequencer #(
    parameter int FRC_DIV = adc_seq_pkg::FRC_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Avalon-MM register slave.
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Core power state.
    input  wire logic        sleep_in,
    // Analog converter interface.
    input  wire logic        cmp_in,
    output logic [12:0]      sar_trial,
    output logic             sample_hold,
    output logic             conv_power,
    // Request outputs.
    output logic             irq_req,
    output logic             wake_req
);
    import adc_seq_pkg::*;

    localparam int FW = $clog2(FRC_DIV + 1);

    // Divide ratio of the system-clock sources; codes ending in 11 are the RC source.
    function automatic logic [6:0] clk_div(input logic [2:0] sel);
        logic [6:0] r;
        r = 7'h02;
        unique case (sel)
            3'b000:  r = 7'h02;
            3'b100:  r = 7'h04;
            3'b001:  r = 7'h08;
            3'b101:  r = 7'h10;
            3'b010:  r = 7'h20;
            3'b110:  r = 7'h40;
            default: r = 7'h02;
        endcase
        return r;
    endfunction

    // Turns the stored sign and magnitude into the sixteen-bit register pair.
    function automatic logic [15:0] format_result(input logic sign, input logic [11:0] mag,
                                                  input logic twos, input logic w10);
        logic [11:0] neg;
        logic [9:0]  neg10;
        logic [15:0] r;
        neg = ~mag + 12'h001;
        neg10 = ~mag[11:2] + 10'h001;
        if (!twos)
        begin
            if (w10)
                r = {mag[11:2], 5'h00, sign};
            else
                r = {mag, 3'h0, sign};
        end
        else if (w10)
            r = {{6{sign}}, sign ? neg10 : mag[11:2]};
        else
            r = {{4{sign}}, sign ? neg : mag};
        return r;
    endfunction

    // Comparator synchroniser.
    logic        cmp_meta_q;
    logic        cmp_sync_q;

    // Bus slave state.
    logic        waitrequest_q;
    logic [31:0] readdata_q;

    // Software-visible registers.
    logic        enable_q;
    logic        go_q;
    logic        width10_q;
    logic        fmt_q;
    logic [2:0]  clksel_q;
    logic        done_q;
    logic        irq_en_q;
    logic        res_sign_q;
    logic [11:0] res_mag_q;

    // Sequencer state.
    seq_state_t  state_q;
    seq_state_t  state_d;
    logic [3:0]  period_q;
    logic [6:0]  div_q;
    logic [FW-1:0] frc_q;
    logic [3:0]  delay_q;
    logic [12:0] trial_q;
    logic [12:0] trial_d;
    logic        sleep_off_q;
    logic        power_q;
    logic        sample_q;
    logic        irq_q;
    logic        wake_q;

    // Bus decode.
    wire         req_new   = (read || write) && waitrequest_q;
    wire         accept    = (read || write) && !waitrequest_q;
    wire         wr_ok     = write && accept && byteenable[0];
    wire         wr_ctrl_a = wr_ok && (address == OFF_CTRL_A);
    wire         wr_ctrl_b = wr_ok && (address == OFF_CTRL_B);
    wire         wr_flag   = wr_ok && (address == OFF_FLAG);
    wire         wr_irq_en = wr_ok && (address == OFF_IRQ_EN);
    wire         new_en    = writedata[EN_BIT];
    wire         new_go    = writedata[GO_BIT];

    // Formatted result, shared by both result reads.
    wire [15:0]  result_word = format_result(res_sign_q, res_mag_q, fmt_q, width10_q);

    // Read selection; unmapped offsets read as zero.
    wire [7:0]   ctrl_a_rd = {width10_q, 5'h00, go_q, enable_q};
    wire [7:0]   ctrl_b_rd = {fmt_q, clksel_q, 4'h0};
    wire [7:0]   rd_byte   = (address == OFF_CTRL_A) ? ctrl_a_rd :
                             (address == OFF_CTRL_B) ? ctrl_b_rd :
                             (address == OFF_RES_HI) ? result_word[15:8] :
                             (address == OFF_RES_LO) ? result_word[7:0] :
                             (address == OFF_FLAG)   ? {7'h00, done_q} :
                             (address == OFF_IRQ_EN) ? {7'h00, irq_en_q} : 8'h00;

    // Bit-period clock sources.
    wire         rc_sel    = (clksel_q[1:0] == 2'b11);
    wire [6:0]   div_last  = clk_div(clksel_q) - 7'h01;
    wire         sys_tick  = (div_q == div_last);
    wire         frc_tick  = (frc_q == FW'(FRC_DIV - 1));
    wire         bit_tick  = rc_sel ? frc_tick : sys_tick;

    // Sequence events.
    wire         busy      = (state_q != ST_IDLE);
    wire         sys_sleep = sleep_in && !rc_sel;
    wire         start     = wr_ctrl_a && new_go && new_en && !go_q && !busy
                             && !sys_sleep;
    wire         sw_abort  = wr_ctrl_a && (!new_go || !new_en) && busy;
    wire         abort     = sw_abort || (sys_sleep && busy);
    wire         finish    = (state_q == ST_CONV) && bit_tick
                             && (period_q == PERIODS_LAST) && !abort;
    wire         delay_end = (delay_q == 4'(INSTR_CYCLES - 1));
    wire [3:0]   bit_idx   = PERIOD_LSB - period_q;

    // Comparator decisions come from the analog side, so they are synchronised first.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end
        else
        begin
            cmp_meta_q <= cmp_in;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Bus handshake: waitrequest drops for exactly one cycle per request.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            waitrequest_q <= 1'b1;
            readdata_q    <= RDATA_RST;
        end
        else
        begin
            waitrequest_q <= !req_new;
            if (req_new && read)
                readdata_q <= {24'h000000, rd_byte};
        end
    end

    // Configuration written by software.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            enable_q  <= 1'b0;
            width10_q <= 1'b0;
            fmt_q     <= 1'b0;
            clksel_q  <= CLKSEL_RST;
            irq_en_q  <= 1'b0;
        end
        else
        begin
            if (wr_ctrl_a)
            begin
                enable_q  <= new_en;
                width10_q <= writedata[WIDTH_BIT];
            end
            if (wr_ctrl_b)
            begin
                fmt_q    <= writedata[FMT_BIT];
                clksel_q <= writedata[SEL_LSB +: 3];
            end
            if (wr_irq_en)
                irq_en_q <= writedata[IRQ_EN_BIT];
        end
    end

    // Go bit: set by the start write, cleared by completion, by a sleep abort or by software.
    always_ff @(posedge clk)
    begin
        if (srst)
            go_q <= 1'b0;
        else if (start)
            go_q <= 1'b1;
        else if (finish || abort)
            go_q <= 1'b0;
        else if (wr_ctrl_a && !new_go)
            go_q <= 1'b0;
    end

    // Done flag; a completion in the same cycle as a software clear wins.
    always_ff @(posedge clk)
    begin
        if (srst)
            done_q <= 1'b0;
        else if (finish)
            done_q <= 1'b1;
        else if (wr_flag)
            done_q <= writedata[DONE_BIT];
    end

    // Result pair: cleared by a start, loaded only by a full conversion.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            res_sign_q <= 1'b0;
            res_mag_q  <= 12'h000;
        end
        else if (start)
        begin
            res_sign_q <= 1'b0;
            res_mag_q  <= 12'h000;
        end
        else if (finish)
        begin
            res_sign_q <= trial_q[12];
            res_mag_q  <= trial_q[11:0];
        end
    end

    // Sequencer transitions.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (start)
                    state_d = rc_sel ? ST_DELAY : ST_CONV;
            ST_DELAY:
                if (abort)
                    state_d = ST_IDLE;
                else if (delay_end && frc_tick)
                    state_d = ST_CONV;
            ST_CONV:
                if (abort || finish)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // An RC start first waits out one instruction cycle on the system clock.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            delay_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            delay_q <= (state_q != ST_DELAY) ? 4'h0 :
                       delay_end ? delay_q : delay_q + 4'h1;
        end
    end

    // The RC source runs free, so a start is held until its next period boundary
    // and no partial first period is ever counted.
    always_ff @(posedge clk)
    begin
        if (srst)
            frc_q <= '0;
        else
            frc_q <= frc_tick ? '0 : frc_q + FW'(1);
    end

    // The system-clock divider restarts with each conversion for an exact first period.
    always_ff @(posedge clk)
    begin
        if (srst || state_q != ST_CONV || sys_tick)
            div_q <= 7'h00;
        else
            div_q <= div_q + 7'h01;
    end

    // Bit-period counter, fifteen periods per conversion.
    always_ff @(posedge clk)
    begin
        if (srst || state_q != ST_CONV)
            period_q <= 4'h0;
        else if (bit_tick)
            period_q <= period_q + 4'h1;
    end

    // Successive approximation: period 0 samples, period 1 decides the sign
    // (comparator high means negative), periods 2 to 13 resolve the magnitude.
    always_comb
    begin
        trial_d = trial_q;
        if (state_q != ST_CONV)
            trial_d = 13'h0000;
        else if (bit_tick && period_q == PERIOD_SIGN)
        begin
            trial_d[12] = cmp_sync_q;
            trial_d[11] = 1'b1;
        end
        else if (bit_tick && period_q > PERIOD_SIGN && period_q <= PERIOD_LSB)
        begin
            trial_d[bit_idx] = cmp_sync_q;
            if (bit_idx != 4'h0)
                trial_d[bit_idx - 4'h1] = 1'b1;
        end
    end

    // Trial register; an abort drops it on the next cycle, leaving the result alone.
    always_ff @(posedge clk)
    begin
        if (srst || abort)
            trial_q <= 13'h0000;
        else
            trial_q <= trial_d;
    end

    // Sleep power-down. Enable keeps reading set; only the analog power drops.
    always_ff @(posedge clk)
    begin
        if (srst || !sleep_in)
            sleep_off_q <= 1'b0;
        else if (sys_sleep)
            sleep_off_q <= 1'b1;
        else if (finish && rc_sel && !irq_en_q)
            sleep_off_q <= 1'b1;
    end

    // Registered outputs toward the analog core and the interrupt controller.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            power_q  <= 1'b0;
            sample_q <= 1'b0;
            irq_q    <= 1'b0;
            wake_q   <= 1'b0;
        end
        else
        begin
            power_q  <= enable_q && !sleep_off_q;
            sample_q <= (state_q == ST_CONV) && (period_q == 4'h0);
            irq_q    <= done_q && irq_en_q;
            wake_q   <= done_q && irq_en_q && sleep_in;
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;
    assign sar_trial   = trial_q;
    assign sample_hold = sample_q;
    assign conv_power  = power_q;
    assign irq_req     = irq_q;
    assign wake_req    = wake_q;

endmodule // adc_conversion_sequencer

// >>> adc_seq_properties.sv
module adc_seq_properties (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        srst,
    // Register bus.
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Power state, converter and requests.
    input wire logic        sleep_in,
    input wire logic [12:0] sar_trial,
    input wire logic        conv_power,
    input wire logic        irq_req,
    input wire logic        wake_req
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Bus handshake: one low cycle of waitrequest per request, never without one.
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer is not a single cycle");
    a_answer_cause: assert property (!waitrequest |-> $past(read || write) && $past(waitrequest))
        else $error("bus answer without a request");
    a_bus_idle: assert property (!(read || write) |=> waitrequest)
        else $error("waitrequest low while idle");
    a_rdata_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("unused read bits not zero");
    // Read data may only move at an answer, so software never sees it shift under it.
    a_rdata_hold: assert property ($changed(readdata) |-> !waitrequest)
        else $error("read data changed outside an answer");
    // Right after reset every request and the converter are quiet.
    a_reset_quiet: assert property ($past(srst) |-> !irq_req && !wake_req && !conv_power
        && sar_trial == 13'h0 && waitrequest)
        else $error("outputs not quiet after reset");
    // A wake request is an interrupt request seen while asleep.
    a_wake_source: assert property (wake_req |-> irq_req && $past(sleep_in))
        else $error("wake request without sleep or interrupt");
    // The request can only drop after software wrote the flag or its enable.
    a_flag_sw_clear: assert property ($fell(irq_req) |-> $past(write, 2))
        else $error("request dropped without a write");

    // Main scenarios reached.
    cover property ($rose(irq_req));
    cover property ($rose(wake_req));
    cover property ($fell(conv_power) && sleep_in);

endmodule // adc_seq_properties

bind adc_conversion_sequencer adc_seq_properties chk (
    .clk(clk), .srst(srst), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_in(sleep_in), .sar_trial(sar_trial),
    .conv_power(conv_power), .irq_req(irq_req), .wake_req(wake_req)
);

// >>> testbench.sv
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;

    typedef struct packed {
        logic [7:0] b;
        logic       w;
        logic       s;
        logic       m;
        logic [7:0] hi;
        logic [7:0] lo;
    } row_t;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic        sleep_in = 1'b0;
    logic        cmp_in = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [12:0] sar_trial;
    logic        sample_hold;
    logic        conv_power;
    logic        irq_req;
    logic        wake_req;
    logic [31:0] rd;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          n;
    int          x;
    // Sign and magnitude decisions with the register images they must give.
    row_t rows [12] = '{
        '{8'h60, 1'b0, 1'b0, 1'b1, 8'hFF, 8'hF0}, '{8'hE0, 1'b0, 1'b0, 1'b1, 8'h0F, 8'hFF},
        '{8'h60, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hF1}, '{8'hE0, 1'b0, 1'b1, 1'b1, 8'hF0, 8'h01},
        '{8'h60, 1'b0, 1'b1, 1'b0, 8'h00, 8'h01}, '{8'hE0, 1'b0, 1'b1, 1'b0, 8'hF0, 8'h00},
        '{8'h60, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00}, '{8'hE0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00},
        '{8'h60, 1'b1, 1'b0, 1'b1, 8'hFF, 8'hC0}, '{8'hE0, 1'b1, 1'b0, 1'b1, 8'h03, 8'hFF},
        '{8'h60, 1'b1, 1'b1, 1'b1, 8'hFF, 8'hC1}, '{8'hE0, 1'b1, 1'b1, 1'b1, 8'hFC, 8'h01}};
    logic [2:0] sel_code [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int         sel_div [8] = '{2, 4, 8, 16, 32, 64, 4, 4};

    // A short RC divider keeps the run brief; expectations use the same 4.
    adc_conversion_sequencer #(.FRC_DIV(4)) dut (
        .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .sleep_in(sleep_in), .cmp_in(cmp_in),
        .sar_trial(sar_trial), .sample_hold(sample_hold), .conv_power(conv_power),
        .irq_req(irq_req), .wake_req(wake_req)
    );

    // Free running 100 MHz clock.
    always #5 clk = ~clk;

    // One bus cycle; the request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 50) mismatches++;
    endtask

    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask

    // Polls the go bit; bounded so a stuck converter cannot hang the run.
    task automatic wait_idle;
        int k;
        k = 0;
        do
        begin
            bus(1'b0, OFF_CTRL_A, 8'h00);
            k++;
        end
        while (rd[GO_BIT] !== 1'b0 && k < 3000);
        if (rd[GO_BIT] !== 1'b0) mismatches++;
    endtask

    // The sign decision is held through period 1, then the magnitude decision from a quarter into period 2.
    task automatic convert(input logic [7:0] b, input logic w, input logic s, input logic m);
        bus(1'b1, OFF_CTRL_B, b);
        bus(1'b1, OFF_CTRL_A, {w, 7'h01});
        cmp_in <= s;
        bus(1'b1, OFF_CTRL_A, {w, 7'h03});
        repeat (8) @(posedge clk);
        `CHK(sample_hold, 1'b1)
        repeat (136) @(posedge clk);
        `CHK(sample_hold, 1'b0)
        `CHK(sar_trial, {s, 12'h800})
        cmp_in <= m;
        wait_idle();
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog: the sequence needs about 17000 cycles, so 40000 leaves ample margin.
    initial
    begin
        #400000;
        mismatches++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i])
        begin
            bus(1'b1, OFF_FLAG, 8'h00);
            convert(rows[i].b, rows[i].w, rows[i].s, rows[i].m);
            chk_rd(OFF_RES_HI, rows[i].hi);
            chk_rd(OFF_RES_LO, rows[i].lo);
            chk_rd(OFF_FLAG, 8'h01);
            chk_rd(OFF_CTRL_B, rows[i].b);
        end
        $display("test formats done");
        bus(1'b1, OFF_IRQ_EN, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, OFF_FLAG, 8'h00);
            bus(1'b1, OFF_CTRL_B, {1'b0, sel_code[i], 4'h0});
            bus(1'b1, OFF_CTRL_A, 8'h01);
            bus(1'b1, OFF_CTRL_A, 8'h03);
            n = 0;
            while (irq_req !== 1'b1 && n < 2000)
            begin
                @(posedge clk);
                n++;
            end
            x = (i > 5) ? 4 : 0;
            `CHK(n >= 15 * sel_div[i] + 1 + x && n <= 15 * sel_div[i] + 3 + 2 * x, 1'b1)
            `CHK(conv_power, 1'b1)
            `CHK(wake_req, 1'b0)
            chk_rd(OFF_CTRL_A, 8'h01);
        end
        $display("test clock sources done");
        // Abort, then go without enable; neither may ever finish.
        bus(1'b1, OFF_IRQ_EN, 8'h00);
        bus(1'b1, OFF_FLAG, 8'h00);
        bus(1'b1, OFF_CTRL_B, 8'h60);
        bus(1'b1, OFF_CTRL_A, 8'h03);
        chk_rd(OFF_RES_HI, 8'h00);
        bus(1'b1, OFF_CTRL_A, 8'h01);
        bus(1'b1, OFF_CTRL_A, 8'h02);
        chk_rd(OFF_CTRL_A, 8'h00);
        repeat (1000) @(posedge clk);
        chk_rd(OFF_FLAG, 8'h00);
        $display("test abort done");
        // Sleep with a system clock source aborts and powers down.
        bus(1'b1, OFF_CTRL_A, 8'h01);
        bus(1'b1, OFF_CTRL_A, 8'h03);
        sleep_in <= 1'b1;
        repeat (1000) @(posedge clk);
        `CHK(conv_power, 1'b0)
        `CHK(sar_trial, 13'h0000)
        bus(1'b0, OFF_CTRL_A, 8'h00);
        `CHK(rd[EN_BIT], 1'b1)
        chk_rd(OFF_FLAG, 8'h00);
        sleep_in <= 1'b0;
        $display("test sleep abort done");
        // RC source in Sleep with the interrupt enabled wakes the core.
        bus(1'b1, OFF_IRQ_EN, 8'h01);
        bus(1'b1, OFF_CTRL_B, 8'h70);
        bus(1'b1, OFF_CTRL_A, 8'h03);
        sleep_in <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(irq_req & wake_req, 1'b1)
        sleep_in <= 1'b0;
        bus(1'b1, OFF_FLAG, 8'h00);
        repeat (4) @(posedge clk);
        `CHK(irq_req, 1'b0)
        // RC source in Sleep without interrupt: finishes, then powers down.
        bus(1'b1, OFF_IRQ_EN, 8'h00);
        bus(1'b1, OFF_CTRL_A, 8'h03);
        sleep_in <= 1'b1;
        repeat (200) @(posedge clk);
        `CHK(conv_power, 1'b0)
        chk_rd(OFF_CTRL_A, 8'h01);
        chk_rd(OFF_FLAG, 8'h01);
        sleep_in <= 1'b0;
        $display("test sleep rc done");
        // Reset in mid conversion.
        bus(1'b1, OFF_CTRL_B, 8'h60);
        bus(1'b1, OFF_CTRL_A, 8'h03);
        repeat (20) @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        chk_rd(OFF_CTRL_A, 8'h00);
        chk_rd(OFF_CTRL_B, 8'h00);
        chk_rd(OFF_FLAG, 8'h00);
        $display("test reset done");
        // Field layout, reserved bits, disabled byte lane and an unmapped address.
        bus(1'b1, OFF_CTRL_A, 8'h81);
        chk_rd(OFF_CTRL_A, 8'h81);
        bus(1'b1, OFF_CTRL_B, 8'hFF);
        chk_rd(OFF_CTRL_B, 8'hF0);
        byteenable <= 4'h0;
        bus(1'b1, OFF_CTRL_B, 8'h00);
        byteenable <= 4'hF;
        chk_rd(OFF_CTRL_B, 8'hF0);
        chk_rd(5'h18, 8'h00);
        $display("test registers done");
        give_verdict();
    end

endmodule // testbench
